//--- src/mrs_alu_map.vh
// register offsets, field layouts, opcodes and constants of the rotate/subtract/skip alu
`ifndef MRS_ALU_MAP_VH
`define MRS_ALU_MAP_VH

// ********************************************
// apb register offsets
// ********************************************
`define MRS_OFF_CTRL 12'h000
`define MRS_OFF_IMM 12'h004
`define MRS_OFF_WORK 12'h008
`define MRS_OFF_FLAGS 12'h00c
`define MRS_OFF_STATUS 12'h010
`define MRS_MEM_PAGE 4'h1
`define MRS_PAGE_FIELD 11:8
`define MRS_WORD_FIELD 7:2

// ********************************************
// field layouts
// ********************************************
`define MRS_CTRL_OP 4:0
`define MRS_CTRL_BIT 10:8
`define MRS_CTRL_ADDR 21:16
`define MRS_FLG_C 0
`define MRS_FLG_AC 1
`define MRS_FLG_Z 2
`define MRS_FLG_OV 3
`define MRS_STS_BUSY 0
`define MRS_STS_SKIP 1
`define MRS_MSB 7
`define MRS_HI_NIB 7:4
`define MRS_LO_NIB 3:0
`define MRS_HALF 4

// ********************************************
// values
// ********************************************
`define MRS_RST_BYTE 8'h00
`define MRS_ALL_ONES 8'hff
`define MRS_ONE_BYTE 8'h01
`define MRS_RST_WORD 32'h00000000
`define MRS_MEM_DEPTH 64

// ********************************************
// opcodes
// ********************************************
`define MRS_OP_NONE 5'h00
`define MRS_OP_ROTATE_LEFT_LINK_MEM 5'h01
`define MRS_OP_ROTATE_LEFT_LINK_TO_WORK 5'h02
`define MRS_OP_ROTATE_RIGHT_MEM 5'h03
`define MRS_OP_ROTATE_RIGHT_TO_WORK 5'h04
`define MRS_OP_ROTATE_RIGHT_LINK_MEM 5'h05
`define MRS_OP_ROTATE_RIGHT_LINK_TO_WORK 5'h06
`define MRS_OP_MINUS_BORROW_TO_WORK 5'h07
`define MRS_OP_MINUS_BORROW_TO_MEM 5'h08
`define MRS_OP_MINUS_TO_WORK 5'h09
`define MRS_OP_MINUS_TO_MEM 5'h0a
`define MRS_OP_MINUS_IMM 5'h0b
`define MRS_OP_DEC_SKIP_ZERO_MEM 5'h0c
`define MRS_OP_DEC_SKIP_ZERO_TO_WORK 5'h0d
`define MRS_OP_INC_SKIP_ZERO_MEM 5'h0e
`define MRS_OP_INC_SKIP_ZERO_TO_WORK 5'h0f
`define MRS_OP_SKIP_BIT_HIGH 5'h10
`define MRS_OP_SET_BYTE 5'h11
`define MRS_OP_SET_BIT 5'h12
`define MRS_OP_NIBBLE_EXCHANGE_MEM 5'h13
`define MRS_OP_NIBBLE_EXCHANGE_TO_WORK 5'h14

`endif

//--- src/mrs_alu.v
// rotate, subtract, skip, set and nibble-exchange datapath behind an apb slave
// Operation
// [RULE1] rotate left through carry in memory: carry into bit 0, bit 7 to carry
// [RULE2] rotate left through carry into work reg; memory untouched, carry takes bit 7
// [RULE3] plain rotate right in memory, bit 0 into bit 7, no flags change
// [RULE4] plain rotate right into work reg; memory and flags untouched
// [RULE5] rotate right through carry in memory; carry into bit 7, bit 0 to carry
// [RULE6] rotate right through carry into work reg; carry takes bit 0, memory kept
// [RULE7] work reg gets work plus inverted memory plus carry; arithmetic flags update
// [RULE8] same borrow subtract written back to memory; arithmetic flags update
// [RULE9] work reg gets work plus inverted memory plus one; arithmetic flags update
// [RULE10] work plus inverted memory plus one written to memory; flags update
// [RULE11] work reg gets work plus inverted immediate plus one; flags update
// [RULE12] true skip drops prefetched instruction: two cycles, else one cycle
// [RULE13] decrement memory, write back, skip when zero, flags unchanged
// [RULE14] memory minus one into work reg, memory kept, skip when zero
// [RULE15] increment memory, write back, skip when zero, flags unchanged
// [RULE16] memory plus one into work reg, memory kept, skip when zero
// [RULE17] skip when the selected memory bit is one, no flag change
// [RULE18] set byte writes all ones to memory, flags unchanged
// [RULE19] set bit forces the selected memory bit to one, rest kept
// [RULE20] nibble exchange in memory, written back, no flag change
// [RULE21] nibble exchange into work reg, memory and flags unchanged
// [RULE22] subtract flags: carry from bit 7, half from bit 3, signed wrap, zero
// [RULE23] non-skipping operations finish in one cycle, result written at its end
`timescale 1ns/1ns
`default_nettype none
`include "mrs_alu_map.vh"

module mrs_alu (
  // clock and reset
  input wire mclk,
  input wire srst,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // core status
  output reg busy,
  output reg discardFetch
);

  // ********************************************
  // states
  // ********************************************
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_EXEC = 2'b01;
  localparam [1:0] ST_DUMMY = 2'b10;

  // ********************************************
  // functions
  // ********************************************
  // returns {signed wrap, nibble carry, carry, sum}
  function [10:0] subOp;
    input [7:0] a;
    input [7:0] b;
    input cin;
    reg [8:0] s;
    reg [4:0] h;
    begin
      s = {1'b0, a} + {1'b0, ~b} + {8'h00, cin}; // [RULE22]
      h = {1'b0, a[`MRS_LO_NIB]} + {1'b0, ~b[`MRS_LO_NIB]} + {4'h0, cin}; // [RULE22]
      subOp = {(a[`MRS_MSB] ^ b[`MRS_MSB]) & (a[`MRS_MSB] ^ s[`MRS_MSB]), h[`MRS_HALF], s}; // [RULE22]
    end
  endfunction

  function isZero;
    input [7:0] v;
    begin
      isZero = (v == `MRS_RST_BYTE);
    end
  endfunction

  // ********************************************
  // storage
  // ********************************************
  reg [7:0] dataMem [0:`MRS_MEM_DEPTH-1];
  reg [1:0] state_q;
  reg [4:0] cmdOp_q;
  reg [2:0] cmdBit_q;
  reg [5:0] cmdAddr_q;
  reg [7:0] imm_q;
  reg [7:0] workReg_q;
  reg linkFlag_q;
  reg nibbleCarryFlag_q;
  reg zeroFlag_q;
  reg signedWrapFlag_q;
  reg lastSkip_q;
  integer i;

  // ********************************************
  // apb decode
  // ********************************************
  wire isMemPage = (paddr[`MRS_PAGE_FIELD] == `MRS_MEM_PAGE);
  wire [5:0] memWord = paddr[`MRS_WORD_FIELD];
  wire accessDone = psel & penable & pready;
  wire readyNext = psel & penable & ~pready & (state_q == ST_IDLE);
  wire wrDone = accessDone & pwrite;
  wire ctrlWr = wrDone & (paddr == `MRS_OFF_CTRL);
  reg [31:0] rdMux;
  reg rdErr;

  always @* begin
    rdMux = `MRS_RST_WORD;
    rdErr = 1'b0;
    if (isMemPage) begin
      rdMux = {24'h000000, dataMem[memWord]};
    end else begin
      case (paddr)
        `MRS_OFF_CTRL: rdMux = {10'h000, cmdAddr_q, 5'h00, cmdBit_q, 3'h0, cmdOp_q};
        `MRS_OFF_IMM: rdMux = {24'h000000, imm_q};
        `MRS_OFF_WORK: rdMux = {24'h000000, workReg_q};
        `MRS_OFF_FLAGS: rdMux = {28'h0000000, signedWrapFlag_q, zeroFlag_q, nibbleCarryFlag_q, linkFlag_q};
        `MRS_OFF_STATUS: rdMux = {30'h00000000, lastSkip_q, busy};
        default: rdErr = 1'b1;
      endcase
    end
  end

  // ********************************************
  // execute datapath
  // ********************************************
  wire [7:0] memRd = dataMem[cmdAddr_q];
  reg [7:0] res;
  reg memWe;
  reg workWe;
  reg linkWe;
  reg arithWe;
  reg newLink;
  reg skipHit;
  reg [10:0] sub;

  always @* begin
    res = memRd;
    memWe = 1'b0;
    workWe = 1'b0;
    linkWe = 1'b0;
    arithWe = 1'b0;
    newLink = linkFlag_q;
    skipHit = 1'b0;
    sub = subOp(workReg_q, memRd, 1'b1);
    case (cmdOp_q)
      `MRS_OP_ROTATE_LEFT_LINK_MEM, `MRS_OP_ROTATE_LEFT_LINK_TO_WORK: begin
        res = {memRd[`MRS_MSB-1:0], linkFlag_q}; // [RULE1] [RULE2]
        newLink = memRd[`MRS_MSB]; // [RULE1] [RULE2]
        linkWe = 1'b1;
        memWe = (cmdOp_q == `MRS_OP_ROTATE_LEFT_LINK_MEM); // [RULE1]
        workWe = ~memWe; // [RULE2]
      end
      `MRS_OP_ROTATE_RIGHT_MEM, `MRS_OP_ROTATE_RIGHT_TO_WORK: begin
        res = {memRd[0], memRd[`MRS_MSB:1]}; // [RULE3] [RULE4]
        memWe = (cmdOp_q == `MRS_OP_ROTATE_RIGHT_MEM); // [RULE3]
        workWe = ~memWe; // [RULE4]
      end
      `MRS_OP_ROTATE_RIGHT_LINK_MEM, `MRS_OP_ROTATE_RIGHT_LINK_TO_WORK: begin
        res = {linkFlag_q, memRd[`MRS_MSB:1]}; // [RULE5] [RULE6]
        newLink = memRd[0]; // [RULE5] [RULE6]
        linkWe = 1'b1;
        memWe = (cmdOp_q == `MRS_OP_ROTATE_RIGHT_LINK_MEM); // [RULE5]
        workWe = ~memWe; // [RULE6]
      end
      `MRS_OP_MINUS_BORROW_TO_WORK, `MRS_OP_MINUS_BORROW_TO_MEM: begin
        sub = subOp(workReg_q, memRd, linkFlag_q); // [RULE7] [RULE8]
        res = sub[7:0];
        arithWe = 1'b1;
        memWe = (cmdOp_q == `MRS_OP_MINUS_BORROW_TO_MEM); // [RULE8]
        workWe = ~memWe; // [RULE7]
      end
      `MRS_OP_MINUS_TO_WORK, `MRS_OP_MINUS_TO_MEM: begin
        res = sub[7:0]; // [RULE9] [RULE10]
        arithWe = 1'b1;
        memWe = (cmdOp_q == `MRS_OP_MINUS_TO_MEM); // [RULE10]
        workWe = ~memWe; // [RULE9]
      end
      `MRS_OP_MINUS_IMM: begin
        sub = subOp(workReg_q, imm_q, 1'b1); // [RULE11]
        res = sub[7:0];
        arithWe = 1'b1;
        workWe = 1'b1;
      end
      `MRS_OP_DEC_SKIP_ZERO_MEM, `MRS_OP_DEC_SKIP_ZERO_TO_WORK: begin
        res = memRd - `MRS_ONE_BYTE; // [RULE13] [RULE14]
        skipHit = isZero(res); // [RULE13] [RULE14]
        memWe = (cmdOp_q == `MRS_OP_DEC_SKIP_ZERO_MEM); // [RULE13]
        workWe = ~memWe; // [RULE14]
      end
      `MRS_OP_INC_SKIP_ZERO_MEM, `MRS_OP_INC_SKIP_ZERO_TO_WORK: begin
        res = memRd + `MRS_ONE_BYTE; // [RULE15] [RULE16]
        skipHit = isZero(res); // [RULE15] [RULE16]
        memWe = (cmdOp_q == `MRS_OP_INC_SKIP_ZERO_MEM); // [RULE15]
        workWe = ~memWe; // [RULE16]
      end
      `MRS_OP_SKIP_BIT_HIGH: begin
        skipHit = memRd[cmdBit_q]; // [RULE17]
      end
      `MRS_OP_SET_BYTE: begin
        res = `MRS_ALL_ONES; // [RULE18]
        memWe = 1'b1;
      end
      `MRS_OP_SET_BIT: begin
        res = memRd | (`MRS_ONE_BYTE << cmdBit_q); // [RULE19]
        memWe = 1'b1;
      end
      `MRS_OP_NIBBLE_EXCHANGE_MEM, `MRS_OP_NIBBLE_EXCHANGE_TO_WORK: begin
        res = {memRd[`MRS_LO_NIB], memRd[`MRS_HI_NIB]}; // [RULE20] [RULE21]
        memWe = (cmdOp_q == `MRS_OP_NIBBLE_EXCHANGE_MEM); // [RULE20]
        workWe = ~memWe; // [RULE21]
      end
      default: begin
        res = memRd;
      end
    endcase
  end

  // ********************************************
  // sequencer and registers
  // ********************************************
  // register writes are stalled while busy, so software and the datapath never write the same cycle
  always @(posedge mclk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cmdOp_q <= `MRS_OP_NONE;
      cmdBit_q <= 3'h0;
      cmdAddr_q <= 6'h00;
      imm_q <= `MRS_RST_BYTE;
      workReg_q <= `MRS_RST_BYTE;
      linkFlag_q <= 1'b0;
      nibbleCarryFlag_q <= 1'b0;
      zeroFlag_q <= 1'b0;
      signedWrapFlag_q <= 1'b0;
      lastSkip_q <= 1'b0;
      busy <= 1'b0;
      discardFetch <= 1'b0;
      prdata <= `MRS_RST_WORD;
      pready <= 1'b0;
      pslverr <= 1'b0;
      for (i = 0; i < `MRS_MEM_DEPTH; i = i + 1) begin
        dataMem[i] <= `MRS_RST_BYTE;
      end
    end else begin
      // one wait state per access; held off entirely while an operation runs
      pready <= readyNext;
      // response fields stand only in the completing cycle, so a stale error never lingers
      prdata <= (readyNext & ~pwrite) ? rdMux : `MRS_RST_WORD;
      pslverr <= readyNext & rdErr;
      if (wrDone) begin
        if (isMemPage) begin
          dataMem[memWord] <= pwdata[7:0];
        end else begin
          case (paddr)
            `MRS_OFF_CTRL: begin
              cmdOp_q <= pwdata[`MRS_CTRL_OP];
              cmdBit_q <= pwdata[`MRS_CTRL_BIT];
              cmdAddr_q <= pwdata[`MRS_CTRL_ADDR];
            end
            `MRS_OFF_IMM: imm_q <= pwdata[7:0];
            `MRS_OFF_WORK: workReg_q <= pwdata[7:0];
            `MRS_OFF_FLAGS: begin
              linkFlag_q <= pwdata[`MRS_FLG_C];
              nibbleCarryFlag_q <= pwdata[`MRS_FLG_AC];
              zeroFlag_q <= pwdata[`MRS_FLG_Z];
              signedWrapFlag_q <= pwdata[`MRS_FLG_OV];
            end
            default: begin
              lastSkip_q <= lastSkip_q;
            end
          endcase
        end
      end
      case (state_q)
        ST_IDLE: begin
          discardFetch <= 1'b0;
          if (ctrlWr) begin
            state_q <= ST_EXEC;
            busy <= 1'b1;
          end
        end
        ST_EXEC: begin
          if (memWe) begin
            dataMem[cmdAddr_q] <= res; // [RULE23]
          end
          if (workWe) begin
            workReg_q <= res; // [RULE23]
          end
          if (linkWe) begin
            linkFlag_q <= newLink; // [RULE1] [RULE5]
          end
          if (arithWe) begin
            linkFlag_q <= sub[8]; // [RULE22]
            nibbleCarryFlag_q <= sub[9]; // [RULE22]
            signedWrapFlag_q <= sub[10]; // [RULE22]
            zeroFlag_q <= isZero(sub[7:0]); // [RULE22]
          end
          lastSkip_q <= skipHit;
          // a skip spends one dummy cycle in place of the dropped prefetch
          if (skipHit) begin
            state_q <= ST_DUMMY; // [RULE12]
            discardFetch <= 1'b1; // [RULE12]
          end else begin
            state_q <= ST_IDLE; // [RULE12] [RULE23]
            busy <= 1'b0;
          end
        end
        ST_DUMMY: begin
          state_q <= ST_IDLE; // [RULE12]
          busy <= 1'b0;
          discardFetch <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy <= 1'b0;
          discardFetch <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

//--- tb/mrs_alu_sva.sv
// port assertions for the rotate/subtract/skip alu
`timescale 1ns/1ns
`default_nettype none
module mrs_alu_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // core status
  input wire logic busy,
  input wire logic discardFetch
);
  default clocking @(posedge mclk); endclocking
  default disable iff (srst);
  // ****
  // checks
  // ****
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held too long");
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  stall_busy_a: assert property (busy |-> !pready) else $error("access completed while busy");
  start_ctrl_a:
    assert property ($rose(busy) |-> $past(psel && penable && pwrite && pready && paddr == 12'h000))
    else $error("busy rose without a control write");
  one_cycle_op_a: assert property ($rose(busy) |=> !busy || discardFetch) else $error("op too long");
  skip_two_a:
    assert property (discardFetch |-> busy ##1 (!busy && !discardFetch)) else $error("skip not two cycles");
  skip_second_a:
    assert property ($rose(discardFetch) |-> $past(busy) && !$past(busy, 2)) else $error("discard misplaced");
  unmapped_err_a: assert property (pready && paddr == 12'h014 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  write_rdata_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("read data on write");
  cover property (discardFetch);
  cover property (pslverr);
  cover property ($rose(busy) ##1 !busy);
  cover property (pready && !pwrite && !pslverr);
endmodule

bind mrs_alu mrs_alu_sva chk_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy), .discardFetch(discardFetch));
`default_nettype wire

//--- tb/mrs_alu_bench.sv
// self-checking bench for the rotate/subtract/skip alu
`timescale 1ns/1ns
`default_nettype none
module mrs_alu_bench;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire busy;
  wire discardFetch;
  int nMismatch = 0;
  int checksDone = 0;
  logic [31:0] rd;
  logic er;

  mrs_alu dut_u (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
    .discardFetch(discardFetch));

  initial forever #50 mclk = ~mclk;
  // ****
  // drivers
  // ****
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nMismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // no cycle count assumed: a stalled access simply waits for pready
  task xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) chk("pready wait", 32'h0, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task run(input logic [4:0] op, input logic [2:0] bs, input logic [7:0] m, input logic [7:0] w,
    input logic [3:0] f);
    logic [7:0] em, ew, b, i, s;
    logic [3:0] ef, af;
    logic [4:0] h;
    logic sk, co, cin;
    int n, nd;
    i = m ^ 8'h5a;
    em = m;
    ew = w;
    ef = f;
    sk = 1'b0;
    b = (op == 5'h0b) ? i : m;
    cin = (op < 5'h09) ? f[0] : 1'b1;
    {co, s} = {1'b0, w} + {1'b0, ~b} + cin;
    h = {1'b0, w[3:0]} + {1'b0, ~b[3:0]} + cin;
    af = {(w[7] ^ b[7]) & (w[7] ^ s[7]), s == 8'h00, h[4], co};
    case (op)
      5'h01: {ef[0], em} = {m, f[0]};
      5'h02: {ef[0], ew} = {m, f[0]};
      5'h03: em = {m[0], m[7:1]};
      5'h04: ew = {m[0], m[7:1]};
      5'h05: {em, ef[0]} = {f[0], m};
      5'h06: {ew, ef[0]} = {f[0], m};
      5'h07, 5'h09, 5'h0b: {ew, ef} = {s, af};
      5'h08, 5'h0a: {em, ef} = {s, af};
      5'h0c: {em, sk} = {m - 8'h01, m == 8'h01};
      5'h0d: {ew, sk} = {m - 8'h01, m == 8'h01};
      5'h0e: {em, sk} = {m + 8'h01, m == 8'hff};
      5'h0f: {ew, sk} = {m + 8'h01, m == 8'hff};
      5'h10: sk = m[bs];
      5'h11: em = 8'hff;
      5'h12: em[bs] = 1'b1;
      5'h13: em = {m[3:0], m[7:4]};
      5'h14: ew = {m[3:0], m[7:4]};
      default: ;
    endcase
    xfer(12'h114, 1'b1, {24'h0, m});
    xfer(12'h008, 1'b1, {24'h0, w});
    xfer(12'h00c, 1'b1, {28'h0, f});
    xfer(12'h004, 1'b1, {24'h0, i});
    xfer(12'h000, 1'b1, {10'h0, 6'h05, 5'h0, bs, 3'h0, op});
    n = 0;
    nd = 0;
    while (busy === 1'b1 && n < 5) begin
      n++;
      if (discardFetch === 1'b1) nd++;
      @(posedge mclk);
    end
    chk("busy cycles", n, 1 + sk);
    chk("discard cycles", nd, sk);
    xfer(12'h114, 1'b0, 32'h0);
    chk("memory byte", rd, em);
    xfer(12'h008, 1'b0, 32'h0);
    chk("work reg", rd, ew);
    xfer(12'h00c, 1'b0, 32'h0);
    chk("flags", rd, ef);
    xfer(12'h010, 1'b0, 32'h0);
    chk("status", rd, {sk, 1'b0});
  endtask
  // ****
  // scenarios
  // ****
  task t_apb;
    xfer(12'h008, 1'b0, 32'h0);
    chk("work after reset", rd, 32'h0);
    xfer(12'h00c, 1'b0, 32'h0);
    chk("flags after reset", rd, 32'h0);
    xfer(12'h014, 1'b0, 32'h0);
    chk("unmapped error", er, 1'b1);
    chk("unmapped data", rd, 32'h0);
    xfer(12'h200, 1'b1, 32'h5);
    chk("unmapped write error", er, 1'b1);
    xfer(12'h010, 1'b1, 32'hff);
    xfer(12'h010, 1'b0, 32'h0);
    chk("status read only", rd, 32'h0);
    $display("bus tests done");
  endtask

  task t_rotate;
    run(5'h01, 3'h0, 8'h80, 8'h11, 4'h0);
    run(5'h02, 3'h0, 8'h01, 8'h22, 4'h9);
    run(5'h03, 3'h0, 8'h01, 8'h33, 4'hf);
    run(5'h04, 3'h0, 8'h81, 8'h44, 4'h6);
    run(5'h05, 3'h0, 8'h01, 8'h55, 4'h1);
    run(5'h06, 3'h0, 8'h02, 8'h66, 4'h1);
    $display("rotate tests done");
  endtask

  task t_subtract;
    run(5'h07, 3'h0, 8'h01, 8'h00, 4'h0);
    run(5'h08, 3'h0, 8'h10, 8'h30, 4'h1);
    run(5'h09, 3'h0, 8'h01, 8'h80, 4'hf);
    run(5'h0a, 3'h0, 8'h5c, 8'h5c, 4'h0);
    run(5'h0b, 3'h0, 8'h33, 8'h20, 4'h0);
    $display("subtract tests done");
  endtask

  task t_skip;
    run(5'h0c, 3'h0, 8'h01, 8'h77, 4'ha);
    run(5'h0c, 3'h0, 8'h00, 8'h77, 4'h5);
    run(5'h0d, 3'h0, 8'h01, 8'h77, 4'ha);
    run(5'h0d, 3'h0, 8'h08, 8'h77, 4'h5);
    run(5'h0e, 3'h0, 8'hff, 8'h77, 4'ha);
    run(5'h0e, 3'h0, 8'h7f, 8'h77, 4'h5);
    run(5'h0f, 3'h0, 8'hff, 8'h77, 4'h3);
    run(5'h10, 3'h7, 8'h80, 8'h77, 4'ha);
    run(5'h10, 3'h3, 8'hf7, 8'h77, 4'h5);
    $display("skip tests done");
  endtask

  task t_setswap;
    run(5'h11, 3'h0, 8'h12, 8'h01, 4'h5);
    run(5'h12, 3'h0, 8'h00, 8'h01, 4'ha);
    run(5'h12, 3'h7, 8'h40, 8'h01, 4'h5);
    run(5'h13, 3'h0, 8'ha5, 8'h01, 4'hc);
    run(5'h14, 3'h0, 8'h3c, 8'h99, 4'h3);
    run(5'h1f, 3'h0, 8'h3c, 8'h99, 4'h3);
    $display("set and exchange tests done");
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", checksDone, nMismatch);
    if (nMismatch == 0 && checksDone > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_apb;
    t_rotate;
    t_subtract;
    t_skip;
    t_setswap;
    end_of_test;
  end

  // the whole run needs about 1000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    nMismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
